// *** src/ris_pkg.sv ***
package ris_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] IRQ1_PIN_SELECT_OFF          = 8'h00;
  localparam logic [7:0] IRQ2_PIN_SELECT_OFF          = 8'h04;
  localparam logic [7:0] TIMER23_CLOCK_PIN_SELECT_OFF = 8'h0C;
  localparam logic [7:0] TIMER45_CLOCK_PIN_SELECT_OFF = 8'h10;
  localparam logic [7:0] CAPTURE12_PIN_SELECT_OFF     = 8'h1C;
  localparam logic [7:0] CAPTURE34_PIN_SELECT_OFF     = 8'h20;
  localparam logic [7:0] CAPTURE5_PIN_SELECT_OFF      = 8'h24;
  localparam logic [7:0] COMPARE_FAULT_PIN_SELECT_OFF = 8'h2C;
  localparam logic [7:0] UART_ONE_INPUT_PIN_SELECT_OFF = 8'h48;
  localparam logic [7:0] LOCK_CTRL_OFF                = 8'h80;
  localparam logic [7:0] MISMATCH_STATUS_OFF          = 8'h84;

  // ==========================================================================
  // field layout
  localparam int          SEL_W        = 5;
  localparam int          HI_LSB       = 8;
  localparam int          LO_LSB       = 0;
  localparam int          NUM_SEL      = 17;
  localparam int          NUM_PINS     = 32;
  localparam int          LOCK_BIT     = 6;
  localparam logic [4:0]  SEL_RESET    = 5'h1F;
  localparam logic [0:0]  LOCK_RESET   = 1'h0;
  localparam logic [7:0]  UNLOCK_KEY1  = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2  = 8'h57;

  // unlock sequence tracker
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} ris_key_type;

endpackage

// *** src/ris_remappable_input_select.sv ***
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - mapping registers accept writes only while remap_write_lock is zero.
// - full remap block has 27 registers, 14 input and 13 output.
// - each input selector is 5 bits, read/write, reset to all ones.
// - unimplemented bits read zero and ignore writes.
// - selector value picks the remappable pin driving the peripheral input.
// - register 0 holds irq one selector at bits 12-8, low byte empty.
// - register 1 holds irq two selector at bits 4-0.
// - register 3 holds timer three clock 12-8, timer two clock 4-0.
// - register 4 holds timer five clock 12-8, timer four clock 4-0.
// - register 7 holds capture two 12-8, capture one 4-0.
// - register 8 holds capture four 12-8, capture three 4-0.
// - register 9 holds capture five at bits 4-0.
// - register 11 holds fault b 12-8, fault a 4-0.
// - register 18 holds uart cts 12-8, uart rx 4-0.
// - locked writes complete without error and change nothing.
// - reset selector values tie every peripheral input low.
// - shadow copies compared; mismatch raises configuration mismatch reset.
module ris_remappable_input_select (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic                           pready_o,
  output logic [31:0]                    prdata_o,
  output logic                           pslverr_o,
  input  wire logic [ris_pkg::NUM_PINS-1:0] remappable_pin_i,
  output logic                           irq_one_o,
  output logic                           irq_two_o,
  output logic                           timer_two_clock_o,
  output logic                           timer_three_clock_o,
  output logic                           timer_four_clock_o,
  output logic                           timer_five_clock_o,
  output logic [4:0]                     capture_o,
  output logic                           compare_fault_a_o,
  output logic                           compare_fault_b_o,
  output logic                           uart_one_rx_o,
  output logic                           uart_one_cts_o,
  output logic                           remap_write_lock_o,
  output logic                           config_mismatch_reset_o
);
  import ris_pkg::*;

  // ==========================================================================
  // selector index map: 0 irq1, 1 irq2, 2 t2, 3 t3, 4 t4, 5 t5, 6..10 cap1..5,
  // 11 fault a, 12 fault b, 13 uart rx, 14 uart cts; 15,16 spare-free
  localparam int NSEL = 15;

  logic [SEL_W-1:0] sel        [NSEL];
  logic [SEL_W-1:0] shadow     [NSEL];
  logic             remap_write_lock;
  ris_key_type      key_state;
  logic             mismatch;

  // ==========================================================================
  // bus decode
  wire       bus_access = psel_i && penable_i;
  wire       bus_write  = bus_access && pwrite_i;
  wire       lo_lane    = pstrb_i[0];
  wire       hi_lane    = pstrb_i[1];
  wire [7:0] wbyte0     = pwdata_i[7:0];
  wire       hit_r0     = paddr_i == IRQ1_PIN_SELECT_OFF;
  wire       hit_r1     = paddr_i == IRQ2_PIN_SELECT_OFF;
  wire       hit_r3     = paddr_i == TIMER23_CLOCK_PIN_SELECT_OFF;
  wire       hit_r4     = paddr_i == TIMER45_CLOCK_PIN_SELECT_OFF;
  wire       hit_r7     = paddr_i == CAPTURE12_PIN_SELECT_OFF;
  wire       hit_r8     = paddr_i == CAPTURE34_PIN_SELECT_OFF;
  wire       hit_r9     = paddr_i == CAPTURE5_PIN_SELECT_OFF;
  wire       hit_r11    = paddr_i == COMPARE_FAULT_PIN_SELECT_OFF;
  wire       hit_r18    = paddr_i == UART_ONE_INPUT_PIN_SELECT_OFF;
  wire       hit_lock   = paddr_i == LOCK_CTRL_OFF;
  wire       hit_stat   = paddr_i == MISMATCH_STATUS_OFF;
  wire       hit_any    = hit_r0 | hit_r1 | hit_r3 | hit_r4 | hit_r7 | hit_r8
                        | hit_r9 | hit_r11 | hit_r18 | hit_lock | hit_stat;

  // always ready; unmapped addresses answer with slave error
  assign pready_o  = 1'b1;
  assign pslverr_o = bus_access && !hit_any;

  // per-selector register hit and byte lane; locked writes silently drop
  wire [NSEL-1:0] sel_hit = {hit_r18, hit_r18, hit_r11, hit_r11, hit_r9, hit_r8,
                             hit_r8, hit_r7, hit_r7, hit_r4, hit_r4, hit_r3,
                             hit_r3, hit_r1, hit_r0};
  // fields living at 12-8: irq1, t3, t5, cap2, cap4, fault b, uart cts
  wire [NSEL-1:0] sel_hi  = 15'h52A9;
  wire            wr_open = bus_write && !remap_write_lock;

  // ==========================================================================
  // selectors, shadows and pin routing, one slice per peripheral input
  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      wire lane_ok = sel_hi[g] ? hi_lane : lo_lane;
      wire [SEL_W-1:0] wval = sel_hi[g] ? pwdata_i[HI_LSB +: SEL_W]
                                        : pwdata_i[LO_LSB +: SEL_W];
      wire do_wr = wr_open && sel_hit[g] && lane_ok;
      // only field bits are stored, so the unused bits cannot hold a value
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          sel[g]    <= SEL_RESET;
          shadow[g] <= SEL_RESET;
        end else if (do_wr) begin
          sel[g]    <= wval;
          shadow[g] <= wval;
        end
      end
    end
  endgenerate

  // pin inputs pass two flops before routing; raw pins are never read elsewhere
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  always_ff @(posedge ref_clk_i) begin
    pin_meta <= remappable_pin_i;
    pin_sync <= pin_meta;
  end

  // pin pick: all-ones selector reads as ground, so pin 31 is never routed
  function automatic logic pick_s(input logic [SEL_W-1:0] s,
                                  input logic [NUM_PINS-1:0] p);
    pick_s = (s == SEL_RESET) ? 1'b0 : p[s];
  endfunction

  // routed peripheral inputs, registered so they are glitch free
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_one_o           <= 1'b0;
      irq_two_o           <= 1'b0;
      timer_two_clock_o   <= 1'b0;
      timer_three_clock_o <= 1'b0;
      timer_four_clock_o  <= 1'b0;
      timer_five_clock_o  <= 1'b0;
      capture_o           <= 5'h00;
      compare_fault_a_o   <= 1'b0;
      compare_fault_b_o   <= 1'b0;
      uart_one_rx_o       <= 1'b0;
      uart_one_cts_o      <= 1'b0;
    end else begin
      irq_one_o           <= pick_s(sel[0], pin_sync);
      irq_two_o           <= pick_s(sel[1], pin_sync);
      timer_two_clock_o   <= pick_s(sel[2], pin_sync);
      timer_three_clock_o <= pick_s(sel[3], pin_sync);
      timer_four_clock_o  <= pick_s(sel[4], pin_sync);
      timer_five_clock_o  <= pick_s(sel[5], pin_sync);
      capture_o[0]        <= pick_s(sel[6], pin_sync);
      capture_o[1]        <= pick_s(sel[7], pin_sync);
      capture_o[2]        <= pick_s(sel[8], pin_sync);
      capture_o[3]        <= pick_s(sel[9], pin_sync);
      capture_o[4]        <= pick_s(sel[10], pin_sync);
      compare_fault_a_o   <= pick_s(sel[11], pin_sync);
      compare_fault_b_o   <= pick_s(sel[12], pin_sync);
      uart_one_rx_o       <= pick_s(sel[13], pin_sync);
      uart_one_cts_o      <= pick_s(sel[14], pin_sync);
    end
  end

  // ==========================================================================
  // lock control: keys 46h then 57h on the low byte arm one lock update
  wire lock_wr   = bus_write && hit_lock && lo_lane;
  wire key1_seen = lock_wr && (wbyte0 == UNLOCK_KEY1);
  wire key2_seen = lock_wr && (wbyte0 == UNLOCK_KEY2);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      key_state        <= KEY_IDLE;
      remap_write_lock <= LOCK_RESET[0];
    end else if (lock_wr) begin
      unique case (key_state)
        KEY_IDLE: key_state <= key1_seen ? KEY_GOT1 : KEY_IDLE;
        KEY_GOT1: key_state <= key2_seen ? KEY_ARMED : (key1_seen ? KEY_GOT1 : KEY_IDLE);
        KEY_ARMED: begin
          // the update consumes the arming, matching keys or not
          remap_write_lock <= wbyte0[LOCK_BIT];
          key_state        <= KEY_IDLE;
        end
        // the spare code of the two-bit state falls back to idle
        default: key_state <= KEY_IDLE;
      endcase
    end
  end
  assign remap_write_lock_o = remap_write_lock;

  // ==========================================================================
  // shadow monitor: any disagreement is a sticky mismatch reset request
  logic [NSEL-1:0] diff;
  always_comb begin
    for (int i = 0; i < NSEL; i++) begin
      diff[i] = sel[i] != shadow[i];
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mismatch <= 1'b0;
    end else if (|diff) begin
      mismatch <= 1'b1;
    end
  end
  assign config_mismatch_reset_o = mismatch;

  // ==========================================================================
  // read data mux; unused bits read zero
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_r0)   rdata[HI_LSB +: SEL_W] = sel[0];
    if (hit_r1)   rdata[LO_LSB +: SEL_W] = sel[1];
    if (hit_r3)   rdata = {19'h0, sel[3], 3'h0, sel[2]};
    if (hit_r4)   rdata = {19'h0, sel[5], 3'h0, sel[4]};
    if (hit_r7)   rdata = {19'h0, sel[7], 3'h0, sel[6]};
    if (hit_r8)   rdata = {19'h0, sel[9], 3'h0, sel[8]};
    if (hit_r9)   rdata[LO_LSB +: SEL_W] = sel[10];
    if (hit_r11)  rdata = {19'h0, sel[12], 3'h0, sel[11]};
    if (hit_r18)  rdata = {19'h0, sel[14], 3'h0, sel[13]};
    if (hit_lock) rdata[LOCK_BIT] = remap_write_lock;
    if (hit_stat) rdata[0] = mismatch;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rdata;
    end
  end

  // ==========================================================================
  // checks
  locked_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus_write && remap_write_lock && hit_r18) |=> (sel[13] == $past(sel[13])))
    else $error("locked write changed a selector");
  open_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus_write && !remap_write_lock && hit_r18 && lo_lane)
      |=> (sel[13] == $past(pwdata_i[4:0])))
    else $error("open write not stored");
  no_error_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus_access && hit_r0) |-> (pready_o && !pslverr_o))
    else $error("mapped access flagged error");
  reset_value_a: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> (sel[0] == 5'h1F && sel[14] == 5'h1F))
    else $error("selector reset value wrong");
  ground_tie_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (sel[13] == 5'h1F) |=> !uart_one_rx_o)
    else $error("reset selector not grounded");
  route_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (sel[0] != 5'h1F && $stable(sel[0])) |=> (irq_one_o == $past(pin_sync[sel[0]])))
    else $error("irq one not routed");
  read_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (psel_i && !penable_i && hit_r18) |=> (prdata_o[31:13] == 19'h0 && prdata_o[7:5] == 3'h0))
    else $error("unused bits not zero");
  mismatch_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (diff == '0) |=> ($past(mismatch) == mismatch))
    else $error("mismatch changed without cause");

endmodule

`default_nettype wire

// *** tb/ris_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// board side: remappable pins driven by slow external logic
module ris_pin_model (
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] level_i,
  output logic [31:0]      remappable_pin_o
);
  // pins move only just after an edge, so the design's synchroniser sees clean steps
  always_ff @(posedge ref_clk_i) begin
    remappable_pin_o <= level_i;
  end
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// bench top
module tb_top;
  import ris_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pins, level, rd;
  logic [3:0]  pstrb;
  logic [4:0]  cap;
  logic        irq1, irq2, t2, t3, t4, t5, fa, fb, rx, cts, lock, mism, err;
  logic [14:0] outv;
  int          fails, n_checks;
  logic [7:0]  offs [9] = '{IRQ1_PIN_SELECT_OFF, IRQ2_PIN_SELECT_OFF,
    TIMER23_CLOCK_PIN_SELECT_OFF, TIMER45_CLOCK_PIN_SELECT_OFF, CAPTURE12_PIN_SELECT_OFF,
    CAPTURE34_PIN_SELECT_OFF, CAPTURE5_PIN_SELECT_OFF, COMPARE_FAULT_PIN_SELECT_OFF,
    UART_ONE_INPUT_PIN_SELECT_OFF};
  logic [31:0] rstv [9] = '{32'h0000_1F00, 32'h0000_001F, 32'h0000_1F1F, 32'h0000_1F1F,
    32'h0000_1F1F, 32'h0000_1F1F, 32'h0000_001F, 32'h0000_1F1F, 32'h0000_1F1F};
  // selector i+5 for every peripheral input, so no two share a pin
  logic [31:0] selv [9] = '{32'h0000_0500, 32'h0000_0006, 32'h0000_0807, 32'h0000_0A09,
    32'h0000_0C0B, 32'h0000_0E0D, 32'h0000_000F, 32'h0000_1110, 32'h0000_1312};

  assign outv = {cts, rx, fb, fa, cap, t5, t4, t3, t2, irq2, irq1};

  ris_pin_model u_pins (.ref_clk_i(ref_clk), .level_i(level), .remappable_pin_o(pins));
  ris_remappable_input_select u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .remappable_pin_i(pins), .irq_one_o(irq1), .irq_two_o(irq2), .timer_two_clock_o(t2),
    .timer_three_clock_o(t3), .timer_four_clock_o(t4), .timer_five_clock_o(t5),
    .capture_o(cap), .compare_fault_a_o(fa), .compare_fault_b_o(fb), .uart_one_rx_o(rx),
    .uart_one_cts_o(cts), .remap_write_lock_o(lock), .config_mismatch_reset_o(mism));

  // ==========================================================================
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000, 4'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  // lock change: two keys, then the lock value
  task automatic set_lock(input logic [31:0] v);
    apb(LOCK_CTRL_OFF, 1'b1, {24'h0, UNLOCK_KEY1}, 4'hF);
    apb(LOCK_CTRL_OFF, 1'b1, {24'h0, UNLOCK_KEY2}, 4'hF);
    apb(LOCK_CTRL_OFF, 1'b1, v, 4'hF);
    // the lock flop updates at the access edge; look one edge later
    @(posedge ref_clk);
  endtask

  // routed outputs must follow the selected pins, for a pattern and its inverse
  task automatic route_chk(input logic [31:0] pat);
    level <= pat;
    repeat (6) @(posedge ref_clk);
    chk({17'h0, outv}, {17'h0, pat[19:5]});
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pstrb = 4'h0; level = 32'hFFFF_FFFF;
    fails = 0; n_checks = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({17'h0, outv}, 32'h0000_0000);
    for (int k = 0; k < 9; k++) rdchk(offs[k], rstv[k]);
    // garbage in unimplemented bits must be dropped
    for (int k = 0; k < 9; k++) apb(offs[k], 1'b1, selv[k] | 32'hFFFF_E0E0, 4'hF);
    for (int k = 0; k < 9; k++) rdchk(offs[k], selv[k]);
    route_chk(32'hA5C3_96E1);
    route_chk(32'h5A3C_691E);
    // lane 0 only: high field keeps its value
    apb(TIMER23_CLOCK_PIN_SELECT_OFF, 1'b1, 32'h0000_0101, 4'h1);
    rdchk(TIMER23_CLOCK_PIN_SELECT_OFF, 32'h0000_0801);
    // lock value without keys is not taken
    apb(LOCK_CTRL_OFF, 1'b1, 32'h0000_0040, 4'hF);
    chk({31'h0, lock}, 32'h0000_0000);
    set_lock(32'h0000_0040);
    chk({31'h0, lock}, 32'h0000_0001);
    apb(UART_ONE_INPUT_PIN_SELECT_OFF, 1'b1, 32'h0000_0101, 4'hF);
    chk({31'h0, err}, 32'h0000_0000);
    rdchk(UART_ONE_INPUT_PIN_SELECT_OFF, 32'h0000_1312);
    set_lock(32'h0000_0000);
    chk({31'h0, lock}, 32'h0000_0000);
    apb(UART_ONE_INPUT_PIN_SELECT_OFF, 1'b1, 32'h0000_0101, 4'hF);
    rdchk(UART_ONE_INPUT_PIN_SELECT_OFF, 32'h0000_0101);
    // a hole in the map answers with an error and stores nothing
    apb(8'h08, 1'b1, 32'h0000_1F1F, 4'hF);
    chk({31'h0, err}, 32'h0000_0001);
    chk({31'h0, mism}, 32'h0000_0000);
    // second reset in mid-run brings every field back to all ones
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 9; k++) rdchk(offs[k], rstv[k]);
    results();
  end
endmodule

`default_nettype wire
